// >>> dv/mode_select_driver.sv
`timescale 1ns/100ps
// ***********************************************
// Mode select conditioning: pattern and clock level driven while drive_en is high
// ***********************************************
module mode_select_driver
(
  input  wire        drive_en,
  input  wire [15:0] pattern,
  input  wire        clk_level,
  output wire [15:0] data_in,
  output wire        clock_source_select
);
  // Released lines fall back to the pull-ups, so no fight with memory
  assign data_in = drive_en ? pattern : 16'hffff;
  // Actively driven in reset; afterwards the level is not to be trusted
  assign clock_source_select = drive_en ? clk_level : ~clk_level;
endmodule // mode_select_driver

// >>> dv/reset_mode_pin_config_sva.sv
`timescale 1ns/100ps
// ******
// Checks
// ******
module reset_mode_pin_config_sva
(
  input wire        ref_clk,
  input wire        rst,
  input wire        internal_reset,
  input wire        boot_chip_select_n,
  input wire        first_bus_cycle,
  input wire        vector_fetch_boot,
  input wire        mode_select_phase,
  input wire [23:0] vector_fetch_addr,
  input wire [2:0]  vector_fetch_fc,
  input wire [15:0] data_oe,
  input wire [10:0] cs_pin_out,
  input wire [7:0]  port_f_pin_oe,
  input wire        boot_port_8bit,
  input wire        use_synthesizer,
  input wire        test_mode,
  input wire        enter_debug,
  input wire        breakpoint_exception,
  input wire        background_debug_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_held;
    internal_reset ##1 internal_reset;
  endsequence
  sequence s_released;
    (!internal_reset)[*4] ##1 !internal_reset;
  endsequence
  property p_boot_cs; s_held |-> boot_chip_select_n; endproperty
  a_boot_cs: assert property (p_boot_cs) else $error("boot select active in reset");
  property p_first_cycle; $fell(internal_reset) |-> ##10 first_bus_cycle; endproperty
  a_first_cycle: assert property (p_first_cycle) else $error("first bus cycle late");
  property p_vector;
    first_bus_cycle |-> vector_fetch_boot && vector_fetch_addr == 24'h0 && vector_fetch_fc == 3'h6;
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector fetch");
  property p_mode_phase; $fell(internal_reset) |-> $past(mode_select_phase); endproperty
  a_mode_phase: assert property (p_mode_phase) else $error("mode selection not first");
  property p_pins; s_held |-> cs_pin_out == 11'h7ff && port_f_pin_oe == 8'h00; endproperty
  a_pins: assert property (p_pins) else $error("pins active in reset");
  property p_defaults; s_held |-> !boot_port_8bit && use_synthesizer && !test_mode; endproperty
  a_defaults: assert property (p_defaults) else $error("no defaults in reset");
  property p_latched;
    s_released |-> $stable({boot_port_8bit, test_mode, use_synthesizer, background_debug_flag});
  endproperty
  a_latched: assert property (p_latched) else $error("mode changed after release");
  property p_no_drive; data_oe == 16'h0000; endproperty
  a_no_drive: assert property (p_no_drive) else $error("data bus driven");
  property p_debug; enter_debug |-> background_debug_flag && !breakpoint_exception; endproperty
  a_debug: assert property (p_debug) else $error("debug entry without flag");
  property p_exc; breakpoint_exception |-> !background_debug_flag; endproperty
  a_exc: assert property (p_exc) else $error("exception with flag set");
endmodule // reset_mode_pin_config_sva

bind reset_mode_pin_config reset_mode_pin_config_sva reset_mode_pin_config_sva_inst (.*);

// >>> dv/reset_mode_pin_config_tb_top.sv
`timescale 1ns/100ps
// *****
// Bench
// *****
module reset_mode_pin_config_tb_top;
  reg         ref_clk = 1'b0;
  reg         rst = 1'b1;
  reg         reset_n = 1'b0;
  reg         drive_en = 1'b1;
  reg         clk_level = 1'b1;
  reg         bk_n = 1'b1;
  reg         ibk_n = 1'b1;
  reg  [15:0] pattern = 16'hffff;
  reg  [15:0] cyc = 16'h0000;
  integer     errors = 0;
  integer     checked = 0;
  wire [15:0] data_in;
  wire        clk_sel;
  wire        boot_n, fbc, dbg, exc, flag, b8, e_en, f_en, tm, syn;
  wire [2:0]  arb, fc, vfc;
  wire [4:0]  addr;
  wire [23:0] vaddr;
  wire [7:0]  pe_oe, pf_oe;
  wire [16:0] cfg = {b8, arb, fc, addr, e_en, f_en, tm, syn, flag};

  always #25 ref_clk = ~ref_clk;

  mode_select_driver mode_select_driver_inst (.drive_en(drive_en), .pattern(pattern),
    .clk_level(clk_level), .data_in(data_in), .clock_source_select(clk_sel));

  reset_mode_pin_config reset_mode_pin_config_inst (.ref_clk(ref_clk), .rst(rst),
    .reset_n(reset_n), .data_in(data_in), .data_out(), .data_oe(),
    .clock_source_select(clk_sel), .breakpoint_input_n(bk_n), .int_breakpoint_n(ibk_n),
    .cs_func_n(cyc[10:0]), .boot_cs_func_n(1'b0), .function_code(cyc[2:0]),
    .addr_func(cyc[4:0]), .bus_grant_n(cyc[0]), .cpu_bus_request(cyc[1]),
    .arb_out_n(cyc[2:0]), .port_e_dout(cyc[7:0]), .port_e_dir(cyc[15:8]),
    .port_f_dout(cyc[8:1]), .port_f_dir(cyc[9:2]), .bus_ctl_dout(cyc[10:3]),
    .bus_ctl_oe(cyc[11:4]), .boot_chip_select_n(boot_n), .cs_pin_out(), .cs_pin_oe(),
    .port_e_pin_out(), .port_e_pin_oe(pe_oe), .port_f_pin_out(), .port_f_pin_oe(pf_oe),
    .boot_port_8bit(b8), .arb_pins_en(arb), .fc_pins_en(fc), .addr_pins_en(addr),
    .general_port_e_en(e_en), .general_port_f_en(f_en), .test_mode(tm),
    .use_synthesizer(syn), .background_debug_flag(flag), .enter_debug(dbg),
    .breakpoint_exception(exc), .internal_reset(), .mode_select_phase(),
    .first_bus_cycle(fbc), .vector_fetch_addr(vaddr), .vector_fetch_fc(vfc),
    .vector_fetch_boot());

  task print_verdict;
    begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // Hang guard: the whole run takes under two hundred cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 16'h0001;
    if (cyc == 16'h03e8)
    begin
      errors = errors + 1;
      print_verdict;
    end
  end

  task chk(input [127:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  function [16:0] expect_cfg(input [15:0] p, input c, input b);
    integer  k;
    reg [4:0] a;
    begin
      for (k = 0; k < 5; k = k + 1)
        a[k] = ~&((p[7:3] >> k) | ~(5'h1f >> k));
      expect_cfg = {~p[0], {3{~p[1]}}, {3{~p[2]}}, a, ~p[8], ~p[9], ~p[11], c, ~b};
    end
  endfunction

  task boot(input [15:0] p, input c, input b);
    integer n;
    begin
      @(posedge ref_clk);
      pattern <= p;
      clk_level <= c;
      bk_n <= b;
      drive_en <= 1'b1;
      reset_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("boot_cs_reset", boot_n, 1);
      chk("port_oe_reset", {pe_oe, pf_oe}, 0);
      reset_n <= 1'b1;
      n = 0;
      while (fbc !== 1'b1 && n < 40)
      begin
        @(posedge ref_clk);
        // Mode logic lets go well before the first bus cycle
        if (n == 5)
        begin
          drive_en <= 1'b0;
          bk_n <= 1'b1;
        end
        #1 n = n + 1;
      end
      // Two pin sync stages, latch, internal release, then ten cycles
      chk("first_cycle", n, 14);
      chk("vector", {vaddr, vfc}, 27'h6);
      chk("boot_cs_run", boot_n, 0);
      chk("mode", cfg, expect_cfg(p, c, b));
    end
  endtask

  task bk_pulse(input ext, input exp_dbg);
    integer n;
    begin
      @(posedge ref_clk);
      if (ext)
        bk_n <= 1'b0;
      else
        ibk_n <= 1'b0;
      n = 0;
      while (dbg !== 1'b1 && exc !== 1'b1 && n < 10)
      begin
        @(posedge ref_clk);
        #1 n = n + 1;
      end
      chk("breakpoint_input_kind", {dbg, exc}, {exp_dbg, ~exp_dbg});
      @(posedge ref_clk);
      bk_n <= 1'b1;
      ibk_n <= 1'b1;
    end
  endtask

  task t_default;
    begin
      boot(16'hffff, 1'b1, 1'b1);
      bk_pulse(1'b0, 1'b0);
    end
  endtask

  task t_alternate;
    begin
      boot(16'hf4d8, 1'b0, 1'b0);
      bk_pulse(1'b1, 1'b1);
    end
  endtask

  task t_addr_steps;
    integer k;
    begin
      for (k = 3; k < 8; k = k + 1)
        boot(~(16'h0001 << k), 1'b1, 1'b1);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_default;
    t_alternate;
    t_addr_steps;
    print_verdict;
  end
endmodule // reset_mode_pin_config_tb_top

// >>> rtl/reset_mode_map.vh
`ifndef RESET_MODE_MAP_VH
`define RESET_MODE_MAP_VH

// Mode-select data line positions
`define MS_BOOT_WIDTH    0
`define MS_ARB_PINS      1
`define MS_FC_PINS       2
`define MS_ADDR_LO       3
`define MS_ADDR_HI       7
`define MS_PORT_E        8
`define MS_PORT_F        9
`define MS_TEST_MODE     11

// First bus cycle delay after reset release, in system clock cycles
`define FIRST_CYCLE_DELAY 4'd10
`define DELAY_W           4

// Reset vector fetch address, supervisor program space
`define RESET_VECTOR_ADDR 24'h000000
`define FC_SUPER_PROGRAM  3'h6

// Reset values of the latched mode word: every line defaults high
`define MODE_WORD_RESET  16'hffff

`endif

// >>> rtl/reset_mode_pin_config.v
`timescale 1ns/100ps
`include "reset_mode_map.vh"

// How it works
// RULE1: Pulled-up lines high select default configuration
// RULE2: First bus cycle ten clocks after release
// RULE3: External mode logic releases bus before then
// RULE4: Boot select high in reset, low after
// RULE5: Vector fetch from address zero, supervisor program
// RULE6: Data line 0 low gives 8-bit boot
// RULE7: Lines 1,2 low reassign chip selects 2:0, 5:3
// RULE8: Lines 7..3 low turn chip selects into address
// RULE9: Data line 8 low gives port E
// RULE10: Data line 9 low gives port F
// RULE11: Data line 11 low enables test mode
// RULE12: Clock select high uses synthesizer, else external
// RULE13: Clock select pin driven actively during reset
// RULE14: Low breakpoint at release sets debug flag
// RULE15: Both high gives breakpoint exception instead
// RULE16: Module pins default to port inputs
// RULE17: Pins inactive in reset; mode selection first
// RULE18: Outputs drive and inputs float after release
// RULE19: General-purpose port pins high impedance after reset
// RULE20: Reset pin synchronised to system clock
// RULE21: Mode values latched at internal reset release
// RULE22: Each pin gets one role via mux
module reset_mode_pin_config
(
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        reset_n,
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg  [15:0] data_oe,
  input  wire        clock_source_select,
  input  wire        breakpoint_input_n,
  input  wire        int_breakpoint_n,
  input  wire [10:0] cs_func_n,
  input  wire        boot_cs_func_n,
  input  wire [2:0]  function_code,
  input  wire [23:19] addr_func,
  input  wire        bus_grant_n,
  input  wire        cpu_bus_request,
  input  wire [2:0]  arb_out_n,
  input  wire [7:0]  port_e_dout,
  input  wire [7:0]  port_e_dir,
  input  wire [7:0]  port_f_dout,
  input  wire [7:0]  port_f_dir,
  input  wire [7:0]  bus_ctl_dout,
  input  wire [7:0]  bus_ctl_oe,
  output reg         boot_chip_select_n,
  output reg  [10:0] cs_pin_out,
  output reg  [10:0] cs_pin_oe,
  output reg  [7:0]  port_e_pin_out,
  output reg  [7:0]  port_e_pin_oe,
  output reg  [7:0]  port_f_pin_out,
  output reg  [7:0]  port_f_pin_oe,
  output reg         boot_port_8bit,
  output reg  [2:0]  arb_pins_en,
  output reg  [2:0]  fc_pins_en,
  output reg  [4:0]  addr_pins_en,
  output reg         general_port_e_en,
  output reg         general_port_f_en,
  output reg         test_mode,
  output reg         use_synthesizer,
  output reg         background_debug_flag,
  output reg         enter_debug,
  output reg         breakpoint_exception,
  output reg         internal_reset,
  output reg         mode_select_phase,
  output reg         first_bus_cycle,
  output reg  [23:0] vector_fetch_addr,
  output reg  [2:0]  vector_fetch_fc,
  output reg         vector_fetch_boot
);

  // ****************************************
  // Sequencer states
  // ****************************************
  localparam [3:0] ST_RESET  = 4'b0001;
  localparam [3:0] ST_WAIT   = 4'b0010;
  localparam [3:0] ST_VECTOR = 4'b0100;
  localparam [3:0] ST_RUN    = 4'b1000;

  // ****************************************
  // Input synchronisation
  // ****************************************
  wire reset_pin_sync;

  // Reset only takes effect on a running clock [RULE20]
  reset_sync u_reset_sync
  (
    .ref_clk  (ref_clk),
    .async_in (reset_n),
    .sync_out (reset_pin_sync)
  );

  reg [15:0] data_meta_q;
  reg [15:0] data_sync_q;
  reg [2:0]  misc_meta_q;
  reg [2:0]  misc_sync_q;

  always @(posedge ref_clk)
  begin
    data_meta_q <= data_in;
    data_sync_q <= data_meta_q;
    misc_meta_q <= {clock_source_select, breakpoint_input_n, int_breakpoint_n};
    misc_sync_q <= misc_meta_q;
  end

  // ****************************************
  // Internal reset and mode latch
  // ****************************************
  wire in_reset = rst | ~reset_pin_sync;

  reg [15:0] mode_q;
  reg        clk_sel_q;
  reg        dbg_q;
  reg        in_reset_q;
  reg [3:0]  state_q;
  reg [3:0]  state_d;
  reg [`DELAY_W-1:0] cnt_q;
  reg [2:0]  breakpoint_input_prev_q;

  wire release_edge = in_reset_q & ~in_reset;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      in_reset_q <= 1'b1;
      mode_q     <= `MODE_WORD_RESET;
      clk_sel_q  <= 1'b1;
      dbg_q      <= 1'b0;
    end
    else
    begin
      in_reset_q <= in_reset;
      // Back to defaults while reset is held, so each boot starts clean [RULE1]
      if (in_reset)
      begin
        mode_q    <= `MODE_WORD_RESET;
        clk_sel_q <= 1'b1;
        dbg_q     <= 1'b0;
      end
      // Latch once at release, hold until next reset [RULE21] [RULE1]
      else if (release_edge)
      begin
        mode_q    <= data_sync_q;
        clk_sel_q <= misc_sync_q[2];
        dbg_q     <= ~misc_sync_q[1] | ~misc_sync_q[0]; // [RULE14] [RULE15]
      end
    end
  end

  // ****************************************
  // Release sequencer: mode select, then vectors
  // ****************************************
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET:  if (release_edge) state_d = ST_WAIT;
      ST_WAIT:   if (cnt_q == `FIRST_CYCLE_DELAY - 4'd1) state_d = ST_VECTOR;
      ST_VECTOR: state_d = ST_RUN;
      ST_RUN:    state_d = ST_RUN;
      default:   state_d = ST_RESET;
    endcase
    if (in_reset)
      state_d = ST_RESET;
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q     <= ST_RESET;
      cnt_q       <= {`DELAY_W{1'b0}};
      breakpoint_input_prev_q <= 3'b111;
    end
    else
    begin
      state_q     <= state_d;
      breakpoint_input_prev_q <= misc_sync_q;
      // Count ten cycles from release to first bus cycle [RULE2]
      if (state_q == ST_WAIT)
        cnt_q <= cnt_q + 4'd1;
      else
        cnt_q <= {`DELAY_W{1'b0}};
    end
  end

  // ****************************************
  // Pin role decode and drive
  // ****************************************
  wire after_reset = ~in_reset_q;
  wire breakpoint_input_fall   = (breakpoint_input_prev_q[1] & ~misc_sync_q[1]) |
                     (breakpoint_input_prev_q[0] & ~misc_sync_q[0]);

  // Chip select 6+k turns address if any line from 3+k up to 7 is low [RULE8]
  wire [4:0] addr_sel_d;
  genvar     g;

  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_addr_sel
      assign addr_sel_d[g] = ~(&mode_q[`MS_ADDR_HI:`MS_ADDR_LO + g]);
    end
  endgenerate

  integer i;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      boot_chip_select_n <= 1'b1;
      port_e_pin_out     <= 8'h00;
      port_e_pin_oe      <= 8'h00;
      port_f_pin_out     <= 8'h00;
      port_f_pin_oe      <= 8'h00;
      data_out           <= 16'h0000;
      data_oe            <= 16'h0000;
      boot_port_8bit     <= 1'b0;
      arb_pins_en        <= 3'h0;
      fc_pins_en         <= 3'h0;
      addr_pins_en       <= 5'h00;
      general_port_e_en  <= 1'b0;
      general_port_f_en  <= 1'b0;
      test_mode          <= 1'b0;
      use_synthesizer    <= 1'b1;
      background_debug_flag <= 1'b0;
      enter_debug        <= 1'b0;
      breakpoint_exception <= 1'b0;
      internal_reset     <= 1'b1;
      mode_select_phase  <= 1'b0;
      first_bus_cycle    <= 1'b0;
      vector_fetch_addr  <= 24'h000000;
      vector_fetch_fc    <= 3'h0;
      vector_fetch_boot  <= 1'b0;
    end
    else
    begin
      internal_reset    <= in_reset_q;
      mode_select_phase <= release_edge; // [RULE17]
      first_bus_cycle   <= (state_q == ST_VECTOR); // [RULE2]
      // Boot select high in reset, active at release [RULE4]
      boot_chip_select_n <= in_reset_q ? 1'b1 : boot_cs_func_n & ~after_reset;
      boot_port_8bit    <= ~mode_q[`MS_BOOT_WIDTH]; // [RULE6]
      arb_pins_en       <= {3{~mode_q[`MS_ARB_PINS]}}; // [RULE7]
      fc_pins_en        <= {3{~mode_q[`MS_FC_PINS]}}; // [RULE7]
      general_port_e_en <= ~mode_q[`MS_PORT_E]; // [RULE9]
      general_port_f_en <= ~mode_q[`MS_PORT_F]; // [RULE10]
      test_mode         <= ~mode_q[`MS_TEST_MODE]; // [RULE11]
      use_synthesizer   <= clk_sel_q; // [RULE12]
      background_debug_flag <= dbg_q;
      enter_debug          <= after_reset & dbg_q & breakpoint_input_fall; // [RULE14]
      breakpoint_exception <= after_reset & ~dbg_q & breakpoint_input_fall; // [RULE15]
      // Vector fetch at zero, supervisor program, via boot select [RULE5]
      if (state_q == ST_VECTOR)
      begin
        vector_fetch_addr <= `RESET_VECTOR_ADDR;
        vector_fetch_fc   <= `FC_SUPER_PROGRAM;
        vector_fetch_boot <= 1'b1;
      end
      else
        vector_fetch_boot <= 1'b0;
      // Data bus is input only here; mode lines are never driven back
      data_out <= 16'h0000;
      data_oe  <= 16'h0000;

      // Each line 7..3 also claims all lower chip selects down to 6 [RULE8]
      addr_pins_en <= addr_sel_d;

      // Port pins: inputs (high impedance) until software sets direction
      // [RULE16] [RULE19] [RULE22]
      for (i = 0; i < 8; i = i + 1)
      begin
        port_e_pin_out[i] <= general_port_e_en ? port_e_dout[i] : bus_ctl_dout[i];
        port_e_pin_oe[i]  <= in_reset_q ? 1'b0 :
                             general_port_e_en ? port_e_dir[i] : bus_ctl_oe[i];
        port_f_pin_out[i] <= port_f_dout[i];
        port_f_pin_oe[i]  <= (in_reset_q | ~general_port_f_en) ? 1'b0 : port_f_dir[i];
      end
    end
  end

  // ****************************************
  // Chip select pin roles, one mux per pin
  // ****************************************
  generate
    for (g = 0; g < 11; g = g + 1)
    begin : g_cs_pin
      wire alt_sel;
      wire alt_out;
      wire alt_oe;

      if (g < 3)
      begin : g_arb
        assign alt_sel = arb_pins_en[g];
        assign alt_out = arb_out_n[g];
        // Only the grant line drives; request and acknowledge are inputs
        assign alt_oe  = (g == 1) ? 1'b1 : 1'b0;
      end
      else if (g < 6)
      begin : g_fc
        assign alt_sel = fc_pins_en[g-3];
        assign alt_out = function_code[g-3];
        assign alt_oe  = 1'b1;
      end
      else
      begin : g_addr
        assign alt_sel = addr_pins_en[g-6];
        assign alt_out = addr_func[g+13];
        assign alt_oe  = 1'b1;
      end

      // Chip select pins: one role each via mux [RULE22] [RULE17] [RULE18]
      always @(posedge ref_clk)
      begin
        if (rst | in_reset_q)
        begin
          cs_pin_out[g] <= 1'b1;
          cs_pin_oe[g]  <= 1'b1;
        end
        else if (alt_sel)
        begin
          cs_pin_out[g] <= alt_out;
          cs_pin_oe[g]  <= alt_oe;
        end
        else
        begin
          cs_pin_out[g] <= cs_func_n[g];
          cs_pin_oe[g]  <= 1'b1;
        end
      end
    end
  endgenerate

endmodule // reset_mode_pin_config

// >>> rtl/reset_sync.v
`timescale 1ns/100ps

// ****************************************
// Two-stage synchroniser for the reset pin
// ****************************************
module reset_sync
(
  input  wire ref_clk,
  input  wire async_in,
  output wire sync_out
);

  reg meta_q;
  reg sync_q;

  // No reset: the pin itself is what we are synchronising
  always @(posedge ref_clk)
  begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end

  assign sync_out = sync_q;

endmodule // reset_sync
